/* File: src/rung_pkg.sv */
/*
 * Opcodes, operand layout, stack depth and reset values for the boolean
 * rung evaluator. Assumes one 40 MHz clock and a program sequencer that
 * presents one instruction at a time and waits for instr_ready.
 */
// Notes on behaviour
// - or_word_bit ORs the rung result with the selected bit of the addressed word.
// - or_inverted_word_bit ORs the rung result with the complement of that bit.
// - the bit selector is BCD 0 to 15 picking one bit of a 16-bit word, direct or by pointer.
// - the series AND ANDs the rung result with the referenced image point.
// - the inverted series AND ANDs the rung result with the complement of the point.
// - and_word_bit and its inverted form AND the rung result with the bit or its complement.
// - branch_and_combine ANDs the two most recent branches, each opened by a store.
// - branch_or_combine ORs the two most recent branches, each opened by a store.
// - the coil writes the present rung result to the addressed image point.
// - with several coils on one location the last one executed decides the final value.
// - branch results are held in an eight-level boolean stack.
// - every store below eight levels pushes the contact state on top and shifts older entries down; on a full stack it pushes nothing.
// - a rung needing more than eight stack levels raises an error.
`default_nettype none
package rung_pkg;
    localparam int STACK_DEPTH = 8;
    localparam int DEPTH_W = 4;
    localparam int ADDR_W = 16;
    localparam int WORD_W = 16;
    localparam int BIT_SEL_W = 8;
    localparam logic [DEPTH_W-1:0] DEPTH_RESET = 4'h0;
    localparam logic [STACK_DEPTH-1:0] STACK_RESET = 8'h00;

    typedef enum logic [3:0] {
        OP_NOP,
        OP_STORE,
        OP_STORE_NOT,
        OP_OR,
        OP_OR_NOT,
        OP_AND,
        OP_AND_NOT,
        OP_STORE_WORD_BIT,
        OP_STORE_NOT_WORD_BIT,
        OP_OR_WORD_BIT,
        OP_OR_INV_WORD_BIT,
        OP_AND_WORD_BIT,
        OP_AND_INV_WORD_BIT,
        OP_BRANCH_AND,
        OP_BRANCH_OR,
        OP_COIL_OUT
    } opcode_t;
endpackage
`default_nettype wire

/* File: src/word_fetch.sv */
/*
 * Resolves a word-bit operand: optional pointer indirection, then a word
 * read and BCD bit select. Assumes word memory answers one cycle after
 * a read request.
 */
`default_nettype none
module word_fetch
    import rung_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic start,
    input wire logic use_pointer,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [BIT_SEL_W-1:0] bit_sel_bcd,
    output logic mem_rd,
    output logic [ADDR_W-1:0] mem_addr,
    input wire logic [WORD_W-1:0] mem_rdata,
    output logic done,
    output logic bit_val,
    output logic bad_sel
);
    typedef enum logic [1:0] {WF_IDLE, WF_PTR, WF_DATA} wf_state_t;
    typedef struct packed {
        wf_state_t st;
        logic done;
        logic bit_val;
        logic bad_sel;
        logic [BIT_SEL_W-1:0] sel;
    } wf_t;
    wf_t s_r, s_nxt;

    // bcd 0..15 to bit index; returns 5'h1F if not a legal selector
    function automatic logic [4:0] bcd_index(input logic [BIT_SEL_W-1:0] b);
        logic [4:0] v;
        v = 5'h1F;
        if (b[7:4] == 4'h0 && b[3:0] <= 4'h9)
            v = {1'b0, b[3:0]};
        else if (b[7:4] == 4'h1 && b[3:0] <= 4'h5)
            v = 5'(b[3:0] + 4'hA);
        return v;
    endfunction

    logic [4:0] idx;
    assign idx = bcd_index(s_r.sel);
    assign done = s_r.done;
    assign bit_val = s_r.bit_val;
    assign bad_sel = s_r.bad_sel;

    always_comb
    begin
        s_nxt = s_r;
        s_nxt.done = 1'b0;
        mem_rd = 1'b0;
        mem_addr = addr;
        case (s_r.st)
            WF_IDLE:
            begin
                if (start)
                begin
                    s_nxt.sel = bit_sel_bcd;
                    mem_rd = 1'b1;
                    s_nxt.st = use_pointer ? WF_PTR : WF_DATA;
                end
            end
            WF_PTR:
            begin
                // pointer word names the data word
                mem_rd = 1'b1;
                mem_addr = mem_rdata;
                s_nxt.st = WF_DATA;
            end
            WF_DATA:
            begin
                s_nxt.bad_sel = idx[4];
                s_nxt.bit_val = idx[4] ? 1'b0 : mem_rdata[idx[3:0]];
                s_nxt.done = 1'b1;
                s_nxt.st = WF_IDLE;
            end
            default: s_nxt.st = WF_IDLE;
        endcase
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            s_r <= '{st: WF_IDLE, sel: 8'h00, default: 1'b0};
        else
            s_r <= s_nxt;
    end
endmodule
`default_nettype wire

/* File: src/ladder_boolean_rung_eval.sv */
/*
 * Boolean rung evaluator: executes contact, branch and coil instructions
 * on an eight-level boolean stack, reading image points and word bits
 * and writing coil results. Assumes the sequencer holds an instruction
 * until instr_ready and pulses rung_start before each rung's first one.
 */
`default_nettype none
module ladder_boolean_rung_eval
    import rung_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic rung_start,
    input wire logic instr_valid,
    output logic instr_ready,
    input wire logic [3:0] instr_op,
    input wire logic [ADDR_W-1:0] instr_addr,
    input wire logic [BIT_SEL_W-1:0] instr_bit_sel,
    input wire logic pointer_word_operand,
    output logic [ADDR_W-1:0] point_addr,
    input wire logic point_value,
    output logic coil_we,
    output logic [ADDR_W-1:0] coil_addr,
    output logic coil_value,
    output logic mem_rd,
    output logic [ADDR_W-1:0] mem_addr,
    input wire logic [WORD_W-1:0] mem_rdata,
    output logic rung_result,
    output logic [DEPTH_W-1:0] stack_level,
    output logic overflow_err,
    output logic underflow_err,
    output logic bit_sel_err
);
    typedef enum logic [1:0] {EV_IDLE, EV_FETCH, EV_WAIT} ev_state_t;
    typedef struct packed {
        ev_state_t st;
        opcode_t op;
        logic [STACK_DEPTH-1:0] stk;
        logic [DEPTH_W-1:0] depth;
        logic coil_we;
        logic [ADDR_W-1:0] coil_addr;
        logic coil_value;
        logic ovf;
        logic unf;
        logic bse;
    } ev_t;
    ev_t s_r, s_nxt;

    logic wf_start;
    logic wf_done;
    logic wf_bit;
    logic wf_bad;

    word_fetch word_fetch_inst (
        .clk(clk),
        .rst(rst),
        .start(wf_start),
        .use_pointer(pointer_word_operand),
        .addr(instr_addr),
        .bit_sel_bcd(instr_bit_sel),
        .mem_rd(mem_rd),
        .mem_addr(mem_addr),
        .mem_rdata(mem_rdata),
        .done(wf_done),
        .bit_val(wf_bit),
        .bad_sel(wf_bad)
    );

    function automatic logic is_word_op(input opcode_t o);
        return o inside {OP_STORE_WORD_BIT, OP_STORE_NOT_WORD_BIT, OP_OR_WORD_BIT,
                         OP_OR_INV_WORD_BIT, OP_AND_WORD_BIT, OP_AND_INV_WORD_BIT};
    endfunction

    // applies a contact to the stack; returns updated stack, depth, error flags
    function automatic logic [STACK_DEPTH+DEPTH_W+1:0] apply_op(
        input opcode_t o,
        input logic c,
        input logic [STACK_DEPTH-1:0] stk,
        input logic [DEPTH_W-1:0] d);
        logic [STACK_DEPTH-1:0] ns;
        logic [DEPTH_W-1:0] nd;
        logic ov;
        logic un;
        ns = stk;
        nd = d;
        ov = 1'b0;
        un = 1'b0;
        case (o)
            OP_STORE, OP_STORE_WORD_BIT, OP_STORE_NOT_WORD_BIT, OP_STORE_NOT:
            begin
                if (d == DEPTH_W'(STACK_DEPTH))
                    ov = 1'b1;
                else
                begin
                    ns = {stk[STACK_DEPTH-2:0], c};
                    nd = d + 4'h1;
                end
            end
            OP_OR, OP_OR_NOT, OP_OR_WORD_BIT, OP_OR_INV_WORD_BIT:
                if (d == DEPTH_RESET) un = 1'b1;
                else ns[0] = stk[0] | c;
            OP_AND, OP_AND_NOT, OP_AND_WORD_BIT, OP_AND_INV_WORD_BIT:
                if (d == DEPTH_RESET) un = 1'b1;
                else ns[0] = stk[0] & c;
            OP_BRANCH_AND, OP_BRANCH_OR:
            begin
                if (d < 4'h2)
                    un = 1'b1;
                else
                begin
                    ns = {1'b0, stk[STACK_DEPTH-1:1]};
                    ns[0] = (o == OP_BRANCH_AND) ? (stk[1] & stk[0]) : (stk[1] | stk[0]);
                    nd = d - 4'h1;
                end
            end
            default: ;
        endcase
        return {ns, nd, ov, un};
    endfunction

    logic inverted;
    logic contact;
    logic [STACK_DEPTH+DEPTH_W+1:0] res;
    opcode_t cur_op;

    assign cur_op = (s_r.st == EV_IDLE) ? opcode_t'(instr_op) : s_r.op;
    assign inverted = cur_op inside {OP_STORE_NOT, OP_OR_NOT, OP_AND_NOT, OP_STORE_NOT_WORD_BIT,
                                     OP_OR_INV_WORD_BIT, OP_AND_INV_WORD_BIT};
    assign contact = (is_word_op(cur_op) ? wf_bit : point_value) ^ inverted;
    assign res = apply_op(cur_op, contact, s_r.stk, s_r.depth);
    assign point_addr = instr_addr;
    assign instr_ready = (s_r.st == EV_IDLE && !is_word_op(opcode_t'(instr_op)))
                         || (s_r.st == EV_WAIT && wf_done);
    // no fetch may start in a cycle that rung_start overrides
    assign wf_start = s_r.st == EV_IDLE && instr_valid && !rung_start
                      && is_word_op(opcode_t'(instr_op));

    assign coil_we = s_r.coil_we;
    assign coil_addr = s_r.coil_addr;
    assign coil_value = s_r.coil_value;
    assign rung_result = s_r.stk[0];
    assign stack_level = s_r.depth;
    assign overflow_err = s_r.ovf;
    assign underflow_err = s_r.unf;
    assign bit_sel_err = s_r.bse;

    always_comb
    begin
        s_nxt = s_r;
        s_nxt.coil_we = 1'b0;
        if (rung_start)
        begin
            s_nxt.stk = STACK_RESET;
            s_nxt.depth = DEPTH_RESET;
            s_nxt.ovf = 1'b0;
            s_nxt.unf = 1'b0;
            s_nxt.bse = 1'b0;
            s_nxt.st = EV_IDLE;
        end
        else
        begin
            case (s_r.st)
                EV_IDLE:
                begin
                    if (instr_valid && wf_start)
                    begin
                        s_nxt.op = opcode_t'(instr_op);
                        s_nxt.st = EV_WAIT;
                    end
                    else if (instr_valid && cur_op == OP_COIL_OUT)
                    begin
                        // each coil writes in program order
                        s_nxt.coil_we = 1'b1;
                        s_nxt.coil_addr = instr_addr;
                        s_nxt.coil_value = s_r.stk[0];
                    end
                    else if (instr_valid)
                    begin
                        s_nxt.stk = res[STACK_DEPTH+DEPTH_W+1:DEPTH_W+2];
                        s_nxt.depth = res[DEPTH_W+1:2];
                        s_nxt.ovf = s_r.ovf | res[1];
                        s_nxt.unf = s_r.unf | res[0];
                    end
                end
                EV_WAIT:
                begin
                    if (wf_done)
                    begin
                        s_nxt.stk = res[STACK_DEPTH+DEPTH_W+1:DEPTH_W+2];
                        s_nxt.depth = res[DEPTH_W+1:2];
                        s_nxt.ovf = s_r.ovf | res[1];
                        s_nxt.unf = s_r.unf | res[0];
                        s_nxt.bse = s_r.bse | wf_bad;
                        s_nxt.st = EV_IDLE;
                    end
                end
                default: s_nxt.st = EV_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            s_r <= '{st: EV_IDLE, op: OP_NOP, stk: STACK_RESET, depth: DEPTH_RESET,
                     coil_addr: 16'h0000, default: 1'b0};
        else
            s_r <= s_nxt;
    end
endmodule
`default_nettype wire

/* File: verif/rung_eval_props.sv */
/* port checker of the boolean rung evaluator
   assumes one rising-edge clock and asynchronous active-high rst */
`default_nettype none
module rung_eval_props
    import rung_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic rung_start,
    input wire logic instr_valid,
    input wire logic instr_ready,
    input wire logic [3:0] instr_op,
    input wire logic [ADDR_W-1:0] instr_addr,
    input wire logic point_value,
    input wire logic coil_we,
    input wire logic [ADDR_W-1:0] coil_addr,
    input wire logic coil_value,
    input wire logic rung_result,
    input wire logic [DEPTH_W-1:0] stack_level,
    input wire logic overflow_err,
    input wire logic underflow_err
);
    timeunit 1ns;
    timeprecision 1ps;
    logic tk;
    logic cmb;
    assign tk = instr_valid && instr_ready && !rung_start;
    assign cmb = instr_op == OP_BRANCH_AND || instr_op == OP_BRANCH_OR;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    a_store_push: assert property (
        tk && instr_op == OP_STORE && stack_level < 4'h8 |=>
        stack_level == $past(stack_level) + 4'h1 && rung_result == $past(point_value))
        else $error("store did not push the contact");
    a_stack_full: assert property (
        tk && instr_op == OP_STORE && stack_level == 4'h8 |=> stack_level == 4'h8 && overflow_err)
        else $error("push on a full stack not flagged");
    a_level_bound: assert property (stack_level <= 4'h8)
        else $error("stack deeper than eight");
    a_and_point: assert property (
        tk && instr_op == OP_AND && stack_level != 4'h0 |=>
        rung_result == ($past(rung_result) & $past(point_value)))
        else $error("series contact wrong");
    a_and_not: assert property (
        tk && instr_op == OP_AND_NOT && stack_level != 4'h0 |=>
        rung_result == ($past(rung_result) & !$past(point_value)))
        else $error("inverted series contact wrong");
    a_combine_pop: assert property (
        tk && cmb && stack_level >= 4'h2 |=> stack_level == $past(stack_level) - 4'h1)
        else $error("combine did not pop one level");
    a_combine_under: assert property (
        tk && cmb && stack_level < 4'h2 |=> underflow_err && $stable(stack_level))
        else $error("short combine not refused");
    a_coil_write: assert property (
        tk && instr_op == OP_COIL_OUT |=> coil_we && coil_value == $past(rung_result)
        && coil_addr == $past(instr_addr))
        else $error("coil write wrong");
    a_rung_clear: assert property (
        rung_start |=> stack_level == 4'h0 && !overflow_err && !underflow_err)
        else $error("rung start did not clear the stack");
endmodule
bind ladder_boolean_rung_eval rung_eval_props rung_eval_props_inst (.clk, .rst, .rung_start,
    .instr_valid, .instr_ready, .instr_op, .instr_addr, .point_value, .coil_we, .coil_addr,
    .coil_value, .rung_result, .stack_level, .overflow_err, .underflow_err);
`default_nettype wire

/* File: verif/image_mem_model.sv */
/* image points and word memory facing the rung evaluator
   assumes low four address bits select a point or a word */
`default_nettype none
module image_mem_model
    import rung_pkg::*;
(
    input wire logic clk,
    input wire logic [ADDR_W-1:0] point_addr,
    output logic point_value,
    input wire logic mem_rd,
    input wire logic [ADDR_W-1:0] mem_addr,
    output logic [WORD_W-1:0] mem_rdata,
    input wire logic coil_we,
    input wire logic [ADDR_W-1:0] coil_addr,
    input wire logic coil_value
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] pts;
    logic [WORD_W-1:0] words [16];
    initial
    begin
        pts = 16'hA5C3;
        mem_rdata = 16'hFFFF;
        for (int k = 0; k < 16; k++)
            words[k] = {4{4'(k)}} ^ 16'h5A3C;
        words[1] = 16'h0002;
    end
    assign point_value = pts[point_addr[3:0]];
    always @(posedge clk)
        mem_rdata <= mem_rd ? words[mem_addr[3:0]] : ~mem_rdata;
    always @(posedge clk)
        if (coil_we)
            pts[coil_addr[3:0]] <= coil_value;
endmodule
`default_nettype wire

/* File: verif/ladder_boolean_rung_eval_tb.sv */
/* self-checking bench of the boolean rung evaluator
   assumes the image and word memory model as far side */
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_errors++; \
    $display("Error at %0t got %h expected %h", $time, a, b); end end
module ladder_boolean_rung_eval_tb
    import rung_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst, rung_start, instr_valid, instr_ready, pointer_word_operand, point_value;
    logic coil_we, coil_value, mem_rd, rung_result, overflow_err, underflow_err, bit_sel_err;
    logic [3:0] instr_op;
    logic [7:0] instr_bit_sel;
    logic [15:0] instr_addr, point_addr, coil_addr, mem_addr, mem_rdata;
    logic [3:0] stack_level;
    int checks = 0;
    int n_errors = 0;
    ladder_boolean_rung_eval ladder_boolean_rung_eval_inst (.clk, .rst, .rung_start,
        .instr_valid, .instr_ready, .instr_op, .instr_addr, .instr_bit_sel,
        .pointer_word_operand, .point_addr, .point_value, .coil_we, .coil_addr, .coil_value,
        .mem_rd, .mem_addr, .mem_rdata, .rung_result, .stack_level, .overflow_err,
        .underflow_err, .bit_sel_err);
    image_mem_model image_mem_model_inst (.clk, .point_addr, .point_value, .mem_rd,
        .mem_addr, .mem_rdata, .coil_we, .coil_addr, .coil_value);
    initial
    begin
        clk = 0;
        forever #12.5 clk = ~clk;
    end
    function automatic logic pts(input int i);
        return image_mem_model_inst.pts[i];
    endfunction
    task conclude;
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task exec(input opcode_t op, input int a, input logic [7:0] bs = 8'h00);
        int i;
        instr_valid = 1;
        instr_op = op;
        instr_addr = 16'(a);
        instr_bit_sel = bs;
        pointer_word_operand = a == 1;
        i = 0;
        #1;
        while (instr_ready !== 1'b1)
        begin
            @(negedge clk);
            #1;
            i++;
            if (i > 8)
            begin
                n_errors++;
                conclude();
            end
        end
        @(negedge clk);
    endtask
    task start;
        rung_start = 1;
        instr_valid = 0;
        @(negedge clk);
        rung_start = 0;
    endtask
    task automatic t_points;
        opcode_t ops [4] = '{OP_OR, OP_OR_NOT, OP_AND, OP_AND_NOT};
        logic e;
        for (int k = 0; k < 4; k++)
            for (int b = 0; b < 4; b++)
            begin
                start();
                exec(OP_STORE, b + 4);
                exec(ops[k], b);
                e = k[1] ? pts(b + 4) & (pts(b) ^ k[0]) : pts(b + 4) | (pts(b) ^ k[0]);
                `CHK(rung_result, e)
            end
    endtask
    task automatic t_word;
        opcode_t ops [4] = '{OP_OR_WORD_BIT, OP_OR_INV_WORD_BIT, OP_AND_WORD_BIT,
            OP_AND_INV_WORD_BIT};
        logic [7:0] sels [4] = '{8'h00, 8'h07, 8'h12, 8'h15};
        logic w;
        for (int k = 0; k < 4; k++)
            for (int s = 0; s < 4; s++)
            begin
                w = image_mem_model_inst.words[2][sels[s][7:4] * 10 + sels[s][3:0]] ^ k[0];
                start();
                exec(OP_STORE, s);
                exec(ops[k], s[0] ? 1 : 2, sels[s]);
                `CHK(rung_result, k[1] ? pts(s) & w : pts(s) | w)
            end
        start();
        exec(OP_STORE_WORD_BIT, 2, 8'h16);
        `CHK({bit_sel_err, rung_result}, 2'b10)
        start();
        `CHK(bit_sel_err, 1'b0)
        w = !image_mem_model_inst.words[2][12];
        exec(OP_STORE_NOT_WORD_BIT, 1, 8'h12);
        `CHK({stack_level, rung_result}, {4'h1, w})
    endtask
    task t_branch;
        start();
        exec(OP_STORE, 0);
        exec(OP_STORE, 2);
        exec(OP_BRANCH_OR, 0);
        `CHK({stack_level, rung_result}, 5'h03)
        exec(OP_STORE, 3);
        exec(OP_BRANCH_AND, 0);
        `CHK({stack_level, rung_result}, 5'h02)
        exec(OP_BRANCH_AND, 0);
        `CHK({stack_level, underflow_err}, 5'h03)
        start();
        `CHK(underflow_err, 1'b0)
    endtask
    task t_stack;
        start();
        for (int i = 0; i < 9; i++)
            exec(OP_STORE, i + 1);
        `CHK({stack_level, overflow_err, rung_result}, 6'h23)
        start();
        `CHK({stack_level, overflow_err}, 5'h00)
    endtask
    task t_coil;
        start();
        exec(OP_STORE, 0);
        exec(OP_COIL_OUT, 12);
        `CHK({coil_we, coil_value, coil_addr}, 18'h3000C)
        start();
        `CHK(pts(12), 1'b1)
        exec(OP_STORE_NOT, 0);
        exec(OP_COIL_OUT, 12);
        start();
        `CHK(pts(12), 1'b0)
    endtask
    initial
    begin
        rst = 1;
        rung_start = 0;
        instr_valid = 0;
        instr_op = 4'h0;
        instr_addr = 16'h0000;
        instr_bit_sel = 8'h00;
        pointer_word_operand = 0;
        repeat (8) @(negedge clk);
        rst = 0;
        t_points();
        t_word();
        t_branch();
        t_stack();
        t_coil();
        conclude();
    end
endmodule
`default_nettype wire
